// ### logic/pswc_defs.vh
// Purpose: constants for the power saving and wakeup controller
// Assumes: word-indexed register map, bus address is the register index
// Notes:   all values as `define macros
//
// Contract
// (R1) wait halts only the cpu; peripherals run; resume at next instruction
// (R2) standby gates all clocks and modules; wakeup resets the cpu
// (R3) refuse wait or standby while motor timer ch3 or ch4 is in pwm
// (R4) key 0x5005 to wait entry enters wait, cpu stopped, pll running
// (R5) writing 0x0001 to wait entry clears the wait wake flag
// (R6) wait entry bit 0 reads 1 after waking from wait until cleared
// (R7) key 0xa00a to standby entry enters standby, cpu and pll stopped
// (R8) writing 0x0001 to standby entry clears the standby wake flag
// (R9) standby entry bit 0 reads 1 after waking from standby until cleared
// (R10) ignore wait and standby requests while emulation debug is active
// (R11) enabled key change wakes the device from any low power mode
// (R12) accept 28 wake event sources from timers, keys, irqs, uart, spi; code ignores motor timer sources 10:7
// (R13) enable bits 15..11: key, uart, spi, ext irq1, ext irq0; 10:8 reserved
// (R14) enable bits 7..4: timer ch2, phase 1, phase 0, match; all reset 0
// (R15) other written values do nothing; only enabled sources end low power
`ifndef PSWC_DEFS_VH
`define PSWC_DEFS_VH
`define PSWC_IDX_WAIT        16'h700c
`define PSWC_IDX_STBY        16'h700e
`define PSWC_IDX_WAKE_EN     16'h700f
`define PSWC_IDX_IRQ_STAT    16'h7010
`define PSWC_IDX_IRQ_MASK    16'h7011
`define PSWC_WAIT_KEY        16'h5005
`define PSWC_STBY_KEY        16'ha00a
`define PSWC_FLAG_CLR        16'h0001
`define PSWC_WAKE_EN_RST     16'h0000
`define PSWC_WAKE_EN_MASK    16'hf8f0
`define PSWC_BIT_KEY         15
`define PSWC_BIT_UART        14
`define PSWC_BIT_SPI         13
`define PSWC_BIT_EXT1        12
`define PSWC_BIT_EXT0        11
`define PSWC_BIT_TMR2        7
`define PSWC_BIT_PH1         6
`define PSWC_BIT_PH0         5
`define PSWC_BIT_CMT         4
`define PSWC_NUM_SRC         28
`define PSWC_RST_PULSE_CYC   4
`endif

// ### logic/pswc_sync3.v
// Purpose: three-flop synchroniser with agreement filter for a bus of pins
// Assumes: inputs are asynchronous to i_clk_sys
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pswc_sync3 #(
    parameter W = 1
) (
    input  wire         i_clk_sys,
    input  wire         i_arst_n,
    input  wire [W-1:0] i_async,
    output reg  [W-1:0] o_sync
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    // first stage feeds only the second; filter looks at stages two and three
    always @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s1_r   <= {W{1'b0}};
            s2_r   <= {W{1'b0}};
            s3_r   <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end
        else
        begin
            s1_r   <= i_async;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            o_sync <= (s2_r & s3_r) | (o_sync & (s2_r | s3_r));
        end
    end
endmodule
`default_nettype wire

// ### logic/pswc_top.v
// Purpose: power mode controller: normal, wait and standby with wake sources
// Assumes: avalon-mm slave, word address = register index, 32-bit data
// Notes:   wake events are level or pulse pins; key change is taken as a level like the rest
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pswc_defs.vh"
module pswc_top #(
    parameter NSRC    = `PSWC_NUM_SRC,
    parameter RST_CYC = `PSWC_RST_PULSE_CYC
) (
    input  wire            i_clk_sys,
    input  wire            i_arst_n,
    // avalon-mm slave
    input  wire [15:0]     i_avs_address,
    input  wire            i_avs_read,
    input  wire            i_avs_write,
    input  wire [31:0]     i_avs_writedata,
    input  wire [3:0]      i_avs_byteenable,
    output reg  [31:0]     o_avs_readdata,
    output wire            o_avs_waitrequest,
    output reg  [1:0]      o_avs_response,
    // wake sources: [27:14] phase timers, [13:11] timer2, [10:7] motor timers,
    // [6:5] match timers, [4] key change, [3:2] ext irq, [1] uart, [0] spi
    input  wire [NSRC-1:0] i_wake_evt,
    input  wire            i_mctl_ch3_pwm,
    input  wire            i_mctl_ch4_pwm,
    input  wire            i_emul_dbg,
    output reg             o_cpu_halt,
    output reg             o_pll_off,
    output reg             o_clk_gate,
    output reg             o_cpu_rst,
    output reg  [1:0]      o_pwr_mode,
    output wire            o_irq
);
    ////////////////////////////////////////////////////////////////////
    localparam [1:0] ST_NORM = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_STBY = 2'b10;
    localparam [1:0] ST_RST  = 2'b11;

    reg  [1:0]      state_r;
    reg  [15:0]     wake_en_r;
    reg             wait_flag_r;
    reg             stby_flag_r;
    reg  [3:0]      irq_stat_r;
    reg  [3:0]      irq_mask_r;
    reg  [7:0]      rst_cnt_r;
    reg             ack_r;
    wire [NSRC-1:0] evt_s;

    // pins arrive from other domains
    pswc_sync3 #(.W(NSRC)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_async   (i_wake_evt),
        .o_sync    (evt_s)
    );
    reg  [2:0] pwm_s1_r;
    reg  [2:0] pwm_s2_r;
    reg  [2:0] pwm_s3_r;
    reg  [2:0] ctl_s_r;
    // control pins: three-flop synchronise, change taken when two and three agree
    always @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pwm_s1_r <= 3'b000;
            pwm_s2_r <= 3'b000;
            pwm_s3_r <= 3'b000;
            ctl_s_r  <= 3'b000;
        end
        else
        begin
            pwm_s1_r <= {i_emul_dbg, i_mctl_ch4_pwm, i_mctl_ch3_pwm};
            pwm_s2_r <= pwm_s1_r;
            pwm_s3_r <= pwm_s2_r;
            ctl_s_r  <= (pwm_s2_r & pwm_s3_r) | (ctl_s_r & (pwm_s2_r | pwm_s3_r));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // (R12) group sources
    function [8:0] group_hits;
        input [NSRC-1:0] e;
        begin
            group_hits[8] = e[4];
            group_hits[7] = e[1];
            group_hits[6] = e[0];
            group_hits[5] = e[3];
            group_hits[4] = e[2];
            group_hits[3] = |e[13:11];
            group_hits[2] = |e[27:21];
            group_hits[1] = |e[20:14];
            group_hits[0] = |e[6:5];
        end
    endfunction

    wire [8:0] hits = group_hits(evt_s);
    wire [8:0] ens  = {wake_en_r[`PSWC_BIT_KEY],  wake_en_r[`PSWC_BIT_UART],
                       wake_en_r[`PSWC_BIT_SPI],  wake_en_r[`PSWC_BIT_EXT1],
                       wake_en_r[`PSWC_BIT_EXT0], wake_en_r[`PSWC_BIT_TMR2],
                       wake_en_r[`PSWC_BIT_PH1],  wake_en_r[`PSWC_BIT_PH0],
                       wake_en_r[`PSWC_BIT_CMT]};
    // (R11) (R15) enabled wake only
    wire wake = |(hits & ens);
    // (R3) (R10) entry blockers
    wire entry_ok = ~ctl_s_r[0] & ~ctl_s_r[1] & ~ctl_s_r[2];

    ////////////////////////////////////////////////////////////////////
    // bus decode: one wait cycle, answer on the second cycle
    wire req  = i_avs_read | i_avs_write;
    wire take = req & ack_r;
    assign o_avs_waitrequest = req & ~ack_r;
    wire lo_be = i_avs_byteenable[0] & i_avs_byteenable[1];
    wire [15:0] wd = i_avs_writedata[15:0];
    wire wr = take & i_avs_write & lo_be;
    wire wr_wait = wr & (i_avs_address == `PSWC_IDX_WAIT);
    wire wr_stby = wr & (i_avs_address == `PSWC_IDX_STBY);
    wire rd_stat = take & i_avs_read & (i_avs_address == `PSWC_IDX_IRQ_STAT);
    wire hit_any = (i_avs_address == `PSWC_IDX_WAIT) |
                   (i_avs_address == `PSWC_IDX_STBY) |
                   (i_avs_address == `PSWC_IDX_WAKE_EN) |
                   (i_avs_address == `PSWC_IDX_IRQ_STAT) |
                   (i_avs_address == `PSWC_IDX_IRQ_MASK);

    // events of this block: wait wake, standby wake, refused entry, key wake
    wire ev_wwake = (state_r == ST_WAIT) & wake;
    wire ev_swake = (state_r == ST_STBY) & wake;
    wire key_try  = (wr_wait & (wd == `PSWC_WAIT_KEY)) |
                    (wr_stby & (wd == `PSWC_STBY_KEY));
    wire ev_refus = key_try & ~entry_ok;
    wire [3:0] ev = {ev_refus, hits[8] & ens[8] & (state_r != ST_NORM),
                     ev_swake, ev_wwake};

    ////////////////////////////////////////////////////////////////////
    // mode state machine and registers
    always @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_r     <= ST_NORM;
            wake_en_r   <= `PSWC_WAKE_EN_RST;
            wait_flag_r <= 1'b0;
            stby_flag_r <= 1'b0;
            irq_stat_r  <= 4'h0;
            irq_mask_r  <= 4'h0;
            rst_cnt_r   <= 8'd0;
            ack_r       <= 1'b0;
        end
        else
        begin
            ack_r <= req & ~ack_r;
            // (R14) (R13) reserved bits stay zero
            if (wr & (i_avs_address == `PSWC_IDX_WAKE_EN))
                wake_en_r <= wd & `PSWC_WAKE_EN_MASK;
            if (wr & (i_avs_address == `PSWC_IDX_IRQ_MASK))
                irq_mask_r <= wd[3:0];
            // sticky status: read clears, new event wins
            irq_stat_r <= (rd_stat ? 4'h0 : irq_stat_r) | ev;
            // (R5) clear; wake set wins
            if (ev_wwake)
                wait_flag_r <= 1'b1;
            else if (wr_wait & (wd == `PSWC_FLAG_CLR))
                wait_flag_r <= 1'b0;
            // (R8) clear; wake set wins
            if (ev_swake)
                stby_flag_r <= 1'b1;
            else if (wr_stby & (wd == `PSWC_FLAG_CLR))
                stby_flag_r <= 1'b0;
            case (state_r)
                ST_NORM:
                begin
                    // (R4) (R7) keys, gated by blockers
                    if (key_try & entry_ok)
                        state_r <= wr_wait ? ST_WAIT : ST_STBY;
                end
                ST_WAIT:
                begin
                    // (R1) resume, no reset
                    if (wake)
                        state_r <= ST_NORM;
                end
                ST_STBY:
                begin
                    // (R2) wake goes through cpu reset
                    if (wake)
                    begin
                        state_r   <= ST_RST;
                        rst_cnt_r <= RST_CYC[7:0];
                    end
                end
                default:
                begin
                    if (rst_cnt_r <= 8'd1)
                        state_r <= ST_NORM;
                    rst_cnt_r <= rst_cnt_r - 8'd1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power outputs from flops
    always @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_cpu_halt <= 1'b0;
            o_pll_off  <= 1'b0;
            o_clk_gate <= 1'b0;
            o_cpu_rst  <= 1'b0;
            o_pwr_mode <= ST_NORM;
        end
        else
        begin
            // (R1) wait: cpu only; (R2) standby: everything off
            o_cpu_halt <= (state_r == ST_WAIT) | (state_r == ST_STBY);
            o_pll_off  <= (state_r == ST_STBY);
            o_clk_gate <= (state_r == ST_STBY);
            o_cpu_rst  <= (state_r == ST_RST);
            o_pwr_mode <= state_r;
        end
    end

    // read data registered at the answer edge; unmapped reads zero, slave error
    always @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_avs_readdata <= 32'h0000_0000;
            o_avs_response <= 2'b00;
        end
        else if (req & ~ack_r)
        begin
            o_avs_response <= hit_any ? 2'b00 : 2'b10;
            // (R6) (R9) flag readback
            if (i_avs_address == `PSWC_IDX_WAIT)
                o_avs_readdata <= {31'h0, wait_flag_r};
            else if (i_avs_address == `PSWC_IDX_STBY)
                o_avs_readdata <= {31'h0, stby_flag_r};
            else if (i_avs_address == `PSWC_IDX_WAKE_EN)
                o_avs_readdata <= {16'h0000, wake_en_r};
            else if (i_avs_address == `PSWC_IDX_IRQ_STAT)
                o_avs_readdata <= {28'h0, irq_stat_r};
            else if (i_avs_address == `PSWC_IDX_IRQ_MASK)
                o_avs_readdata <= {28'h0, irq_mask_r};
            else
                o_avs_readdata <= 32'h0000_0000;
        end
    end

    assign o_irq = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

// ### bench/pswc_monitor.sv
// Purpose: port assertions for the power mode controller
// Assumes: one clock domain, async active-low reset
// Notes:   bound from the test top file
`timescale 1ns/1ps
`default_nettype none
`include "pswc_defs.vh"
module pswc_monitor #(
    parameter RST_CYC = 4
) (
    input wire logic        i_clk_sys,
    input wire logic        i_arst_n,
    input wire logic [15:0] i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [1:0]  o_avs_response,
    input wire logic        i_mctl_ch3_pwm,
    input wire logic        i_mctl_ch4_pwm,
    input wire logic        i_emul_dbg,
    input wire logic        o_cpu_halt,
    input wire logic        o_pll_off,
    input wire logic        o_clk_gate,
    input wire logic        o_cpu_rst,
    input wire logic [1:0]  o_pwr_mode
);
    logic [3:0] blk_cnt_r;
    logic [7:0] rst_cnt_r;
    wire        blk = i_emul_dbg | i_mctl_ch3_pwm | i_mctl_ch4_pwm;
    wire        req = i_avs_read | i_avs_write;
    wire        hit = i_avs_address inside {`PSWC_IDX_WAIT, `PSWC_IDX_STBY,
                      `PSWC_IDX_WAKE_EN, `PSWC_IDX_IRQ_STAT, `PSWC_IDX_IRQ_MASK};
    ////////////////////////////////////////////////////////////////
    // blocker age saturates at 8, long past the synchroniser delay
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            blk_cnt_r <= 4'd0;
            rst_cnt_r <= 8'd0;
        end
        else
        begin
            blk_cnt_r <= !blk ? 4'd0 : (blk_cnt_r == 4'd8 ? 4'd8 : blk_cnt_r + 4'd1);
            rst_cnt_r <= o_cpu_rst ? rst_cnt_r + 8'd1 : 8'd0;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////////
    a_wait_outputs:
    assert property (o_pwr_mode == 2'd1 |-> o_cpu_halt && !o_pll_off && !o_cpu_rst)
        else $error("wait mode outputs wrong");
    a_stby_outputs:
    assert property (o_pwr_mode == 2'd2 |-> o_cpu_halt && o_pll_off && o_clk_gate)
        else $error("standby outputs wrong");
    a_norm_outputs:
    assert property (o_pwr_mode == 2'd0 |-> !o_cpu_halt && !o_pll_off && !o_clk_gate)
        else $error("normal mode outputs wrong");
    a_rst_length:
    assert property ($fell(o_cpu_rst) |-> rst_cnt_r == RST_CYC)
        else $error("cpu reset pulse length wrong");
    a_wait_exit:
    assert property (o_pwr_mode == 2'd1 |=> o_pwr_mode inside {2'd0, 2'd1})
        else $error("wait left to a bad mode");
    a_bus_answer:
    assert property ($rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("bus answer timing wrong");
    a_bus_resp_code:
    assert property (req && !o_avs_waitrequest |-> o_avs_response == (hit ? 2'b00 : 2'b10)
        && (!i_avs_read || o_avs_readdata[31:16] == 16'h0000))
        else $error("bus response wrong");
    a_block_entry:
    assert property (blk_cnt_r == 4'd8 && o_pwr_mode == 2'd0 |=> o_pwr_mode == 2'd0)
        else $error("low power entered while blocked");
endmodule
`default_nettype wire

// ### bench/pswc_partner.sv
// Purpose: model of the peripheral wake event sources
// Assumes: one source fired at a time
// Notes:   each event stands 4 cycles so the 3-flop filter sees it
`timescale 1ns/1ps
`default_nettype none
module pswc_partner (
    input  wire logic        i_clk_sys,
    input  wire logic        i_fire,
    input  wire logic [4:0]  i_src,
    output logic      [27:0] o_wake_evt
);
    logic [2:0] hold_r = 3'd0;
    logic [4:0] src_r = 5'd0;
    always @(posedge i_clk_sys)
    begin
        if (i_fire)
        begin
            src_r <= i_src;
            hold_r <= 3'd4;
        end
        else if (hold_r != 3'd0)
            hold_r <= hold_r - 3'd1;
    end
    assign o_wake_evt = (hold_r != 3'd0) ? (28'h1 << src_r) : 28'h0;
endmodule
`default_nettype wire

// ### bench/pswc_top_test.sv
// Purpose: self-checking test of the power mode controller
// Assumes: avalon slave answers after one wait cycle
// Notes:   short reset pulse parameter for the standby wake
`timescale 1ns/1ps
`default_nettype none
`include "pswc_defs.vh"
module pswc_top_test;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        wreq;
    logic [2:0]  blk = 3'b000;
    logic        fire = 1'b0;
    logic [4:0]  src = 5'h00;
    logic [27:0] evt;
    logic [1:0]  mode;
    logic        irq;
    int          error_cnt = 0;
    int          tests_run = 0;
    always #2 clk = ~clk;
    pswc_top #(.RST_CYC(4)) u_dut (.i_clk_sys(clk), .i_arst_n(arst_n),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .o_avs_response(), .i_wake_evt(evt), .i_mctl_ch3_pwm(blk[0]),
        .i_mctl_ch4_pwm(blk[1]), .i_emul_dbg(blk[2]), .o_cpu_halt(), .o_pll_off(),
        .o_clk_gate(), .o_cpu_rst(), .o_pwr_mode(mode), .o_irq(irq));
    pswc_partner u_src (.i_clk_sys(clk), .i_fire(fire), .i_src(src), .o_wake_evt(evt));
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // request held until the rising edge after waitrequest is seen low at a falling edge
    task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {16'h0000, d};
        @(negedge clk);
        while (wreq !== 1'b0 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 50)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk("reg", {16'h0000, e}, q);
    endtask
    task automatic wait_mode(input logic [1:0] m);
        int n;
        n = 0;
        while (mode !== m && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk("mode", {30'h0, m}, {30'h0, mode});
        if (n == 200)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic pulse(input logic [4:0] s);
        @(posedge clk);
        fire <= 1'b1;
        src <= s;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(`PSWC_IDX_WAKE_EN, 16'h0000);
        bus(1'b1, `PSWC_IDX_WAKE_EN, 16'hffff);
        rd_chk(`PSWC_IDX_WAKE_EN, `PSWC_WAKE_EN_MASK);
        rd_chk(16'h7012, 16'h0000);
        // wait mode: only key change may wake
        bus(1'b1, `PSWC_IDX_WAKE_EN, 16'h8000);
        bus(1'b1, `PSWC_IDX_WAIT, `PSWC_WAIT_KEY);
        wait_mode(2'd1);
        pulse(5'd1);
        repeat (12) @(negedge clk);
        chk("mode", 32'h1, {30'h0, mode});
        pulse(5'd4);
        wait_mode(2'd0);
        rd_chk(`PSWC_IDX_WAIT, 16'h0001);
        bus(1'b1, `PSWC_IDX_WAIT, 16'h0002);
        rd_chk(`PSWC_IDX_WAIT, 16'h0001);
        bus(1'b1, `PSWC_IDX_WAIT, `PSWC_FLAG_CLR);
        rd_chk(`PSWC_IDX_WAIT, 16'h0000);
        // standby woken by the uart, then a cpu reset
        bus(1'b1, `PSWC_IDX_WAKE_EN, 16'h4000);
        bus(1'b1, `PSWC_IDX_STBY, `PSWC_STBY_KEY);
        wait_mode(2'd2);
        pulse(5'd1);
        wait_mode(2'd3);
        wait_mode(2'd0);
        rd_chk(`PSWC_IDX_STBY, 16'h0001);
        bus(1'b1, `PSWC_IDX_STBY, `PSWC_FLAG_CLR);
        rd_chk(`PSWC_IDX_STBY, 16'h0000);
        // each blocker refuses entry; refusal is sticky but masked
        bus(1'b1, `PSWC_IDX_IRQ_MASK, 16'h0000);
        bus(1'b0, `PSWC_IDX_IRQ_STAT, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            blk <= 3'b001 << i;
            repeat (8) @(posedge clk);
            bus(1'b1, i == 1 ? `PSWC_IDX_STBY : `PSWC_IDX_WAIT,
                i == 1 ? `PSWC_STBY_KEY : `PSWC_WAIT_KEY);
            repeat (12) @(negedge clk);
            chk("mode", 32'h0, {30'h0, mode});
            @(posedge clk);
            blk <= 3'b000;
            repeat (8) @(posedge clk);
        end
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, `PSWC_IDX_IRQ_MASK, 16'h0008);
        @(negedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk(`PSWC_IDX_IRQ_STAT, 16'h0008);
        @(negedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        end_of_test();
    end
endmodule
bind pswc_top pswc_monitor #(.RST_CYC(RST_CYC)) u_mon (.i_clk_sys, .i_arst_n, .i_avs_address,
    .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_avs_response,
    .i_mctl_ch3_pwm, .i_mctl_ch4_pwm, .i_emul_dbg, .o_cpu_halt, .o_pll_off, .o_clk_gate,
    .o_cpu_rst, .o_pwr_mode);
`default_nettype wire
